// file: inc/safety_eval_pkg.sv
// package for the testable safety sensor evaluation block
// assumes a 200 MHz clock and an APB slave with 32-bit data
package safety_eval_pkg;
    localparam int          CLOCK_PERIOD_PS = 5000;
    localparam int          TICK_TIME_PS    = 1000000000;
    localparam int          TICK_CYCLES     = TICK_TIME_PS / CLOCK_PERIOD_PS;
    localparam int          FILTER_MIN_MS   = 3;
    localparam int          FILTER_MAX_MS   = 250;
    // register byte offsets
    localparam logic [7:0]  CTRL_OFFS       = 8'h00;
    localparam logic [7:0]  TIME_OFFS       = 8'h04;
    localparam logic [7:0]  STATUS_OFFS     = 8'h08;
    localparam logic [7:0]  IRQ_STAT_OFFS   = 8'h0c;
    localparam logic [7:0]  IRQ_MASK_OFFS   = 8'h10;
    // control fields
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_RST_EN     = 2;
    localparam int          CTRL_RST_MON    = 3;
    localparam int          CTRL_SIM_EN     = 4;
    localparam int          CTRL_TEST_EN    = 5;
    localparam int          CTRL_PWR_TEST   = 6;
    localparam int          CTRL_ERR_OUT_EN = 7;
    localparam int          CTRL_RESET_VAL  = 0;
    // timing fields
    localparam int          TIME_FILT_LSB   = 0;
    localparam int          TIME_SIM_LSB    = 8;
    localparam logic [7:0]  FILT_RESET_VAL  = 8'h03;
    localparam logic [7:0]  SIM_RESET_VAL   = 8'h64;
    // interrupt bits
    localparam int          IRQ_SIM_ERR     = 0;
    localparam int          IRQ_TEST_ERR    = 1;
    localparam int          IRQ_SAFE_FALL   = 2;
    localparam int          IRQ_W           = 3;
    // test pulse half-period in ticks
    localparam int          TEST_PERIOD_MS  = 4;

    typedef enum logic [1:0] {
        MODE_SINGLE_NC,
        MODE_SINGLE_NO,
        MODE_DUAL_NC,
        MODE_DUAL_NC_NO
    } contact_mode_t;
endpackage

// file: src/contact_filter.sv
// debounce filter for one contact input
// assumes a pre-synchronised input and a one-cycle ms tick
`timescale 1ns/1ps
module contact_filter
    import safety_eval_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       tick_i,
    input  wire logic [7:0] filter_ms_i,
    input  wire logic       raw_i,
    output logic            level_o
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic       level_reg;
    logic       level_next;

    always_comb begin
        count_next = count_reg;
        level_next = level_reg;
        if (raw_i == level_reg) begin
            count_next = 8'h00;
        end else if (tick_i) begin
            // new level accepted only after stable ticks
            if (count_reg + 8'h01 >= filter_ms_i) begin
                level_next = raw_i;
                count_next = 8'h00;
            end else begin
                count_next = count_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            count_reg <= 8'h00;
            level_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;
endmodule // contact_filter

// file: src/safety_sensor_eval.sv
// testable safety sensor evaluation with APB register access
// assumes contact and reset inputs arrive asynchronously from pins
//
// Operation
// - single NC: output follows filtered input
// - single NO: output follows filtered input
// - dual NC: output only when both one
// - dual NC-NO: output when first one, second zero
// - dual modes: late partner change raises simultaneity error
// - simultaneity check only when enabled
// - window in ms bounds channel transition gap
// - reset disabled: output follows inputs directly
// - reset enabled: fresh reset after each activation
// - manual reset: accept rising edge
// - monitored reset: accept rise then fall
// - test pulses detect shorted cables
// - power-on test: activate and release first
// - debounce filter 3 to 250 ms
// - errors shown on error output when enabled
// - single and dual channel configurations supported
`timescale 1ns/1ps
module safety_sensor_eval
    import safety_eval_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic        CLOCK_I,
    input  wire logic        RSTN_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        FIRST_CHANNEL_INPUT_I,
    input  wire logic        SECOND_CHANNEL_INPUT_I,
    input  wire logic        RESET_INPUT_I,
    output logic             TEST_OUT1_O,
    output logic             TEST_OUT2_O,
    output logic             SAFE_O,
    output logic             ERROR_O,
    output logic             IRQ_O
);
    if (TICK_DIV < 2) begin : g_tick_div_check
        $error("TICK_DIV must be at least 2");
    end

    // ------------------------------------------------------------
    // input synchronisers and ms tick
    // ------------------------------------------------------------
    logic [2:0]  sync1_reg;
    logic [2:0]  sync2_reg;
    logic [31:0] div_reg;
    logic [31:0] div_next;
    logic        tick;

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {RESET_INPUT_I, SECOND_CHANNEL_INPUT_I, FIRST_CHANNEL_INPUT_I};
            sync2_reg <= sync1_reg;
        end
    end

    assign tick = (div_reg == 32'(TICK_DIV - 1));

    always_comb begin
        div_next = tick ? 32'h0 : div_reg + 32'h1;
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            div_reg <= 32'h0;
        end else begin
            div_reg <= div_next;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]       ctrl_reg;
    logic [7:0]       ctrl_next;
    logic [7:0]       filt_reg;
    logic [7:0]       filt_next;
    logic [7:0]       simw_reg;
    logic [7:0]       simw_next;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_mask_next;
    logic [31:0]      prdata_reg;
    logic [31:0]      prdata_next;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;
    logic [IRQ_W-1:0] irq_events;
    contact_mode_t    mode;

    assign mode    = contact_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
    assign addr_ok = (PADDR_I == CTRL_OFFS) || (PADDR_I == TIME_OFFS) ||
                     (PADDR_I == STATUS_OFFS) || (PADDR_I == IRQ_STAT_OFFS) ||
                     (PADDR_I == IRQ_MASK_OFFS);
    assign wr_en   = PSEL_I && PENABLE_I && PWRITE_I && addr_ok;
    // read word latched in setup so it stands through the access phase
    assign rd_en   = PSEL_I && !PENABLE_I && !PWRITE_I;

    // ------------------------------------------------------------
    // filtering and evaluation
    // ------------------------------------------------------------
    logic in1_f;
    logic in2_f;
    logic test_active;
    logic test_phase_reg;
    logic test_phase_next;

    logic test_hold;

    // filters frozen while test lines are low, so a pulse never reaches safe
    assign test_hold = test_active && test_phase_reg;
    contact_filter u_filt1 (
        .clock_i     (CLOCK_I),
        .rstn_i      (RSTN_I),
        .tick_i      (tick),
        .filter_ms_i (filt_reg),
        .raw_i       (test_hold ? in1_f : sync2_reg[0]),
        .level_o     (in1_f)
    );

    contact_filter u_filt2 (
        .clock_i     (CLOCK_I),
        .rstn_i      (RSTN_I),
        .tick_i      (tick),
        .filter_ms_i (filt_reg),
        .raw_i       (test_hold ? in2_f : sync2_reg[1]),
        .level_o     (in2_f)
    );

    logic dual;
    logic active_cond;
    logic inactive_cond;

    assign dual = (mode == MODE_DUAL_NC) || (mode == MODE_DUAL_NC_NO);

    always_comb begin
        active_cond   = 1'b0;
        inactive_cond = 1'b0;
        unique case (mode)
            MODE_SINGLE_NC: begin
                active_cond   = in1_f;
                inactive_cond = !in1_f;
            end
            MODE_SINGLE_NO: begin
                active_cond   = in1_f;
                inactive_cond = !in1_f;
            end
            MODE_DUAL_NC: begin
                active_cond   = in1_f && in2_f;
                inactive_cond = !in1_f && !in2_f;
            end
            MODE_DUAL_NC_NO: begin
                active_cond   = in1_f && !in2_f;
                inactive_cond = !in1_f && in2_f;
            end
        endcase
    end

    // ------------------------------------------------------------
    // simultaneity, test pulses, reset and power-on test
    // ------------------------------------------------------------
    logic [7:0] sim_cnt_reg;
    logic [7:0] sim_cnt_next;
    logic       sim_run_reg;
    logic       sim_run_next;
    logic       in1_d_reg;
    logic       in2_d_reg;
    logic       sim_err_reg;
    logic       sim_err_next;
    logic       test_err_reg;
    logic       test_err_next;
    logic [2:0] tp_cnt_reg;
    logic [2:0] tp_cnt_next;
    logic       rst_d_reg;
    logic       rst_armed_reg;
    logic       rst_armed_next;
    logic       latched_reg;
    logic       latched_next;
    logic       pwr_ok_reg;
    logic       pwr_ok_next;
    logic       pwr_seen_reg;
    logic       pwr_seen_next;
    logic       safe_reg;
    logic       safe_next;
    logic       ch1_edge;
    logic       ch2_edge;
    logic       any_err;
    logic       rst_accept;

    assign ch1_edge    = in1_f != in1_d_reg;
    assign ch2_edge    = in2_f != in2_d_reg;
    assign any_err     = sim_err_reg || test_err_reg;
    assign test_active = ctrl_reg[CTRL_TEST_EN];

    always_comb begin
        sim_cnt_next  = sim_cnt_reg;
        sim_run_next  = sim_run_reg;
        sim_err_next  = sim_err_reg;
        test_err_next = test_err_reg;
        tp_cnt_next   = tp_cnt_reg;
        test_phase_next = test_phase_reg;
        rst_armed_next = rst_armed_reg;
        latched_next  = latched_reg;
        pwr_ok_next   = pwr_ok_reg;
        pwr_seen_next = pwr_seen_reg;
        rst_accept    = 1'b0;
        // one channel switched alone: start the window, or stop it if running
        if (dual && ctrl_reg[CTRL_SIM_EN]) begin
            if (ch1_edge ^ ch2_edge) begin
                sim_run_next = !sim_run_reg;
                sim_cnt_next = 8'h00;
            end else if (sim_run_reg && tick) begin
                sim_cnt_next = sim_cnt_reg + 8'h01;
                // compared before the increment: a 255 window cannot wrap
                if (sim_cnt_reg >= simw_reg) begin
                    sim_err_next = 1'b1;
                    sim_run_next = 1'b0;
                end
            end
        end else begin
            sim_run_next = 1'b0;
            sim_cnt_next = 8'h00;
        end
        // test pulse: contact must read low while its test line is off
        if (test_active && tick) begin
            tp_cnt_next = tp_cnt_reg + 3'h1;
            if (tp_cnt_reg == 3'(TEST_PERIOD_MS - 1)) begin
                tp_cnt_next     = 3'h0;
                test_phase_next = !test_phase_reg;
            end
        end
        if (test_active && test_phase_reg && tp_cnt_reg == 3'h2 && tick &&
            (sync2_reg[0] || (dual && sync2_reg[1]))) begin
            test_err_next = 1'b1;
        end
        // errors clear once the evaluated inputs are back inactive
        if (any_err && inactive_cond) begin
            sim_err_next  = 1'b0;
            test_err_next = 1'b0;
        end
        // reset input handling
        if (!rst_d_reg && sync2_reg[2]) begin
            if (ctrl_reg[CTRL_RST_MON]) begin
                rst_armed_next = 1'b1;
            end else begin
                rst_accept = 1'b1;
            end
        end
        if (rst_armed_reg && rst_d_reg && !sync2_reg[2]) begin
            rst_accept     = 1'b1;
            rst_armed_next = 1'b0;
        end
        if (!active_cond) begin
            latched_next = 1'b0;
        end else if (rst_accept) begin
            latched_next = 1'b1;
        end
        // power-on test: see active then inactive once
        if (active_cond) begin
            pwr_seen_next = 1'b1;
        end
        if (pwr_seen_reg && inactive_cond) begin
            pwr_ok_next = 1'b1;
        end
    end

    always_comb begin
        safe_next = active_cond && !any_err &&
                    (!ctrl_reg[CTRL_RST_EN] || latched_reg) &&
                    (!ctrl_reg[CTRL_PWR_TEST] || pwr_ok_reg);
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            sim_cnt_reg    <= 8'h00;
            sim_run_reg    <= 1'b0;
            sim_err_reg    <= 1'b0;
            test_err_reg   <= 1'b0;
            tp_cnt_reg     <= 3'h0;
            test_phase_reg <= 1'b0;
            in1_d_reg      <= 1'b0;
            in2_d_reg      <= 1'b0;
            rst_d_reg      <= 1'b0;
            rst_armed_reg  <= 1'b0;
            latched_reg    <= 1'b0;
            pwr_ok_reg     <= 1'b0;
            pwr_seen_reg   <= 1'b0;
            safe_reg       <= 1'b0;
        end else begin
            sim_cnt_reg    <= sim_cnt_next;
            sim_run_reg    <= sim_run_next;
            sim_err_reg    <= sim_err_next;
            test_err_reg   <= test_err_next;
            tp_cnt_reg     <= tp_cnt_next;
            test_phase_reg <= test_phase_next;
            in1_d_reg      <= in1_f;
            in2_d_reg      <= in2_f;
            rst_d_reg      <= sync2_reg[2];
            rst_armed_reg  <= rst_armed_next;
            latched_reg    <= latched_next;
            pwr_ok_reg     <= pwr_ok_next;
            pwr_seen_reg   <= pwr_seen_next;
            safe_reg       <= safe_next;
        end
    end

    // ------------------------------------------------------------
    // bus slave and interrupts
    // ------------------------------------------------------------
    assign irq_events = {safe_reg && !safe_next, test_err_next && !test_err_reg,
                         sim_err_next && !sim_err_reg};

    always_comb begin
        ctrl_next     = ctrl_reg;
        filt_next     = filt_reg;
        simw_next     = simw_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        prdata_next   = prdata_reg;
        if (wr_en && PADDR_I == CTRL_OFFS) begin
            ctrl_next = PWDATA_I[7:0];
        end
        if (wr_en && PADDR_I == TIME_OFFS) begin
            // filter clamped into its legal range
            if (PWDATA_I[TIME_FILT_LSB +: 8] < 8'(FILTER_MIN_MS)) begin
                filt_next = 8'(FILTER_MIN_MS);
            end else if (PWDATA_I[TIME_FILT_LSB +: 8] > 8'(FILTER_MAX_MS)) begin
                filt_next = 8'(FILTER_MAX_MS);
            end else begin
                filt_next = PWDATA_I[TIME_FILT_LSB +: 8];
            end
            simw_next = PWDATA_I[TIME_SIM_LSB +: 8];
        end
        if (wr_en && PADDR_I == IRQ_MASK_OFFS) begin
            irq_mask_next = PWDATA_I[IRQ_W-1:0];
        end
        if (wr_en && PADDR_I == IRQ_STAT_OFFS) begin
            irq_stat_next = irq_stat_reg & ~PWDATA_I[IRQ_W-1:0];
        end
        // set wins over a simultaneous clear
        irq_stat_next = irq_stat_next | irq_events;
        if (rd_en) begin
            unique case (PADDR_I)
                CTRL_OFFS:     prdata_next = {24'h0, ctrl_reg};
                TIME_OFFS:     prdata_next = {16'h0, simw_reg, filt_reg};
                STATUS_OFFS:   prdata_next = {26'h0, pwr_ok_reg, latched_reg, test_err_reg,
                                              sim_err_reg, in2_f, in1_f};
                IRQ_STAT_OFFS: prdata_next = {29'h0, irq_stat_reg};
                IRQ_MASK_OFFS: prdata_next = {29'h0, irq_mask_reg};
                default:       prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            ctrl_reg     <= 8'(CTRL_RESET_VAL);
            filt_reg     <= FILT_RESET_VAL;
            simw_reg     <= SIM_RESET_VAL;
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            prdata_reg   <= 32'h0;
        end else begin
            ctrl_reg     <= ctrl_next;
            filt_reg     <= filt_next;
            simw_reg     <= simw_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            prdata_reg   <= prdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PRDATA_O    = prdata_reg;
    assign PREADY_O    = 1'b1;
    assign PSLVERR_O   = PSEL_I && PENABLE_I && !addr_ok;
    assign SAFE_O      = safe_reg;
    assign ERROR_O     = ctrl_reg[CTRL_ERR_OUT_EN] && any_err;
    assign IRQ_O       = |(irq_stat_reg & irq_mask_reg);
    assign TEST_OUT1_O = !(test_active && test_phase_reg);
    assign TEST_OUT2_O = !(test_active && test_phase_reg);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_safe_needs_active: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        SAFE_O |-> $past(active_cond))
        else $error("safe output without active inputs");
    a_error_blocks_safe: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        $past(any_err) |-> !SAFE_O)
        else $error("safe output during error");
    a_sim_off_no_err: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        (!ctrl_reg[CTRL_SIM_EN] && !sim_err_reg) |=> !sim_err_reg)
        else $error("simultaneity error while disabled");
    a_reset_gates_safe: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        (ctrl_reg[CTRL_RST_EN] && !latched_reg) |=> !SAFE_O)
        else $error("safe output before reset");
    a_pwr_test_gate: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        (ctrl_reg[CTRL_PWR_TEST] && !pwr_ok_reg) |=> !SAFE_O)
        else $error("safe output before power-on test");
    a_err_out_en: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        ERROR_O |-> ctrl_reg[CTRL_ERR_OUT_EN])
        else $error("error output while disabled");
    a_direct_follow: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        (!ctrl_reg[CTRL_RST_EN] && !ctrl_reg[CTRL_PWR_TEST] && !any_err && active_cond)
        |=> SAFE_O)
        else $error("safe output not following inputs");
    a_filter_min: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I)
        filt_reg >= 8'(FILTER_MIN_MS) && filt_reg <= 8'(FILTER_MAX_MS))
        else $error("filter time out of range");
endmodule // safety_sensor_eval

// file: verification/sensor_contacts.sv
// model of the safety sensor contacts and the reset pushbutton
// assumes the bench sets contact states; test lines come from the block
`timescale 1ns/1ps
module sensor_contacts (
    input  wire logic test1_i,
    input  wire logic test2_i,
    input  wire logic closed1_i,
    input  wire logic closed2_i,
    input  wire logic short_i,
    input  wire logic press_i,
    output logic      first_o,
    output logic      second_o,
    output logic      button_o
);
    // a closed contact returns its test line; a short to supply on the first contact stays high only while that contact is closed
    assign first_o  = closed1_i & (test1_i | short_i);
    assign second_o = closed2_i & test2_i;
    // pushbutton wired to the input after the last sensor input
    assign button_o = press_i;
endmodule // sensor_contacts

// file: verification/testable_safety_sensor_eval_tb.sv
// self-checking bench for the safety sensor evaluation block
// assumes a 1 ms tick of 20 clocks, so one ms is 100 ns here
`timescale 1ns/1ps
module testable_safety_sensor_eval_tb;
    import safety_eval_pkg::*;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, d;
    logic        c1 = 0, c2 = 0, shrt = 0, press = 0, slverr;
    logic        in1, in2, btn, t1, t2, seen_low;
    logic [31:0] prdata;
    logic        pready, pslverr, safe, err, irq;
    int          failures = 0, compares = 0;
    always #2.5 clk = ~clk;
    safety_sensor_eval #(.TICK_DIV(20)) dut_u (
        .CLOCK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FIRST_CHANNEL_INPUT_I(in1),
        .SECOND_CHANNEL_INPUT_I(in2), .RESET_INPUT_I(btn), .TEST_OUT1_O(t1),
        .TEST_OUT2_O(t2), .SAFE_O(safe), .ERROR_O(err), .IRQ_O(irq));
    sensor_contacts part_u (.test1_i(t1), .test2_i(t2), .closed1_i(c1), .closed2_i(c2),
        .short_i(shrt), .press_i(press), .first_o(in1), .second_o(in2), .button_o(btn));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] v);
        psel <= 1; pwrite <= wr; paddr <= a; pwdata <= v; penable <= 0;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        d = prdata;
        slverr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic set(input logic a, input logic b, input int n);
        c1 <= a;
        c2 <= b;
        wt(n);
    endtask
    task automatic do_reset();
        rstn <= 0;
        wt(12);
        rstn <= 1;
        @(posedge clk);
    endtask
    function automatic logic ex(input int m, input logic a, input logic b);
        case (m)
            0, 1: return a;
            2: return a & b;
            default: return a & ~b;
        endcase
    endfunction
    task automatic complete_run();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        do_reset();
        xfer(0, CTRL_OFFS, 0); chk(d, 0);
        xfer(0, TIME_OFFS, 0); chk(d[15:0], {SIM_RESET_VAL, FILT_RESET_VAL});
        xfer(0, 8'h14, 0); chk(d, 0); chk(slverr, 1);
        chk(safe, 0);
        $display("test reset values done");
        for (int m = 0; m < 4; m++) begin
            xfer(1, CTRL_OFFS, m);
            for (int c = 0; c < 4; c++) begin
                set(c[1], c[0], 200);
                chk(safe, ex(m, c[1], c[0]));
            end
        end
        $display("test contact modes done");
        xfer(1, CTRL_OFFS, 0); xfer(1, TIME_OFFS, 32'h6405); set(0, 0, 200);
        set(1, 0, 60); chk(safe, 0);
        wt(140); chk(safe, 1);
        xfer(1, TIME_OFFS, 32'h0203); set(0, 0, 200);
        $display("test filter done");
        for (int k = 0; k < 2; k++) begin
            xfer(1, CTRL_OFFS, 32'h4 | (k << 3));
            set(1, 0, 200); chk(safe, 0);
            press <= 1; wt(200); chk(safe, k == 0);
            press <= 0; wt(40); chk(safe, 1);
            set(0, 0, 200); set(1, 0, 200); chk(safe, 0);
            press <= 1; wt(40); press <= 0; wt(40); set(0, 0, 200);
        end
        $display("test reset handling done");
        for (int k = 0; k < 2; k++) begin
            xfer(1, CTRL_OFFS, 32'h82 | (k << 4));
            xfer(1, IRQ_STAT_OFFS, 32'h7);
            set(1, 0, 400); set(1, 1, 200);
            chk(err, k);
            chk(safe, !k);
            if (k == 1) begin
                xfer(0, IRQ_STAT_OFFS, 0); chk(d[IRQ_SIM_ERR], 1); chk(d, 32'h1);
                xfer(1, IRQ_MASK_OFFS, 0); chk(irq, 0);
                xfer(1, IRQ_MASK_OFFS, 32'h7); chk(irq, 1);
                xfer(1, IRQ_STAT_OFFS, 32'h7); xfer(0, IRQ_STAT_OFFS, 0); chk(d, 0);
                chk(irq, 0);
            end
            set(0, 0, 200); chk(err, 0);
            set(1, 1, 200); chk(safe, 1);
            set(0, 0, 200);
        end
        set(1, 0, 20); set(1, 1, 200); chk(err, 0); chk(safe, 1);
        set(0, 0, 200);
        $display("test simultaneity done");
        xfer(1, CTRL_OFFS, 32'ha0); set(1, 0, 600); chk(err, 0); chk(safe, 1);
        shrt <= 1; seen_low = 0;
        repeat (600) begin
            @(posedge clk);
            seen_low |= (t1 === 1'b0) && (t2 === 1'b0);
        end
        chk(seen_low, 1);
        chk(err, 1);
        shrt <= 0;
        $display("test pulses done");
        set(1, 0, 2);
        do_reset();
        xfer(1, CTRL_OFFS, 32'h40); wt(200); chk(safe, 0);
        set(0, 0, 200); set(1, 0, 200); chk(safe, 1);
        $display("test power-on done");
        complete_run();
    end
    initial begin
        wt(60000);
        failures++;
        complete_run();
    end
endmodule // testable_safety_sensor_eval_tb
